// >>> bench/tcsu_cpu_model.sv
module tcsu_cpu_model (
	input wire logic ref_clk,
	input wire logic irq,
	output logic woke
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sleeping core leaves wait on any timer request
	always_ff @(posedge ref_clk) woke <= irq === 1'b1;
endmodule // tcsu_cpu_model

// >>> bench/tcsu_timer_assertions.sv
module tcsu_timer_assertions (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic stop_mode,
	input wire logic capture_irq,
	input wire logic compare_irq,
	input wire logic rollover_irq,
	input wire logic timer_irq
);
	import tcsu_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence s_stat_rd;
		reg_rd && reg_addr == OFS_STAT;
	endsequence
	a_irq_merge: assert property (timer_irq == (capture_irq | compare_irq | rollover_irq)) else $error("merge");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("idle");
	a_stat_unused: assert property (s_stat_rd |=> reg_rdata[4:0] == 5'h00) else $error("unused");
	a_stat_cap: assert property (s_stat_rd ##0 capture_irq |=> reg_rdata[7]) else $error("cap");
	a_stat_cmp: assert property (s_stat_rd ##0 compare_irq |=> reg_rdata[6]) else $error("cmp");
	a_stat_roll: assert property (s_stat_rd ##0 rollover_irq |=> reg_rdata[5]) else $error("roll");
	a_alt_keep: assert property (reg_rd && reg_addr == OFS_ALT_LO && rollover_irq |=> rollover_irq) else $error("alt");
	// Bus access excluded: a clear or enable write may move a request in stop
	a_stop_irq: assert property (stop_mode && $past(stop_mode && !reg_rd && !reg_wr) |-> $stable(timer_irq)) else $error("stop");
endmodule // tcsu_timer_assertions

bind tcsu_timer tcsu_timer_assertions tcsu_timer_assertions_i (.*);

// >>> bench/tcsu_timer_tb.sv
module tcsu_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tcsu_pkg::*;
	logic ref_clk, rstn, reg_wr, reg_rd, pin, stop, cmp_pin, irq, woke;
	logic [2:0] iv;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, d;
	int errors, checks_done, seed;
	tcsu_timer tcsu_timer_i (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.capture_input_pin(pin), .stop_mode(stop), .compare_output_pin(cmp_pin), .capture_irq(iv[2]),
		.compare_irq(iv[1]), .rollover_irq(iv[0]), .timer_irq(irq));
	tcsu_cpu_model tcsu_cpu_model_i (.ref_clk, .irq, .woke);
	initial begin
		ref_clk = 0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic wr(input logic [7:0] a, v);
		@(posedge ref_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 0;
		#1 rv = reg_rdata;
	endtask
	task automatic chk(input logic [7:0] g, e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	// Bounded poll so a dead flag cannot hang the run
	task automatic ws(input int b);
		rv = 0;
		for (int i = 0; i < 200 && rv[b] !== 1'b1; i++) rd(OFS_STAT);
		if (rv[b] !== 1'b1) begin
			errors++;
			conclude();
		end
	endtask
	function automatic logic [7:0] ctrl_exp(input logic [7:0] v);
		return v & CTRL_WMASK;
	endfunction
	task automatic conclude;
		if (errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		seed = 54;
		errors = 0;
		checks_done = 0;
		{rstn, reg_wr, reg_rd, pin, stop} = 0;
		reg_addr = 0;
		reg_wdata = 0;
		repeat (6) @(posedge ref_clk);
		rstn <= 1;
		rd(OFS_CTRL);
		chk(rv, CTRL_RESET);
		rd(OFS_CNT_HI);
		chk(rv, CNT_RESET[15:8]);
		chk({7'h00, cmp_pin}, 8'h00);
		// Reads eight cycles apart: exactly two counter steps
		rd(OFS_CNT_LO);
		d = rv;
		repeat (6) @(posedge ref_clk);
		rd(OFS_CNT_LO);
		chk(rv, d + 8'h02);
		// Enables kept off while unreset flags may still be unknown
		d = 8'($random(seed)) & 8'h1F;
		wr(OFS_CTRL, d);
		rd(OFS_CTRL);
		chk(rv, ctrl_exp(d));
		wr(OFS_CMP_HI, 8'h00);
		wr(OFS_CMP_LO, 8'h40);
		ws(STAT_CMP);
		chk({7'h00, cmp_pin}, {7'h00, d[0]});
		wr(OFS_CTRL, d | 8'h60);
		rd(OFS_STAT);
		chk(rv, 8'h60);
		chk({5'h00, iv}, 8'h03);
		wr(OFS_CMP_LO, 8'h40);
		rd(OFS_ALT_LO);
		chk({5'h00, iv}, 8'h01);
		rd(OFS_CNT_LO);
		chk({5'h00, iv}, 8'h00);
		for (int e = 0; e < 2; e++) begin
			@(posedge ref_clk) pin <= e[0];
			wr(OFS_CTRL, {1'b1, 5'h00, e[0], 1'b0});
			@(posedge ref_clk) pin <= !e[0];
			rd(OFS_STAT);
			chk(rv, 8'h00);
			@(posedge ref_clk) pin <= e[0];
			ws(STAT_CAP);
			chk({5'h00, iv}, 8'h04);
			rd(OFS_CAP_LO);
			chk({5'h00, iv}, 8'h00);
		end
		@(posedge ref_clk) stop <= 1;
		rd(OFS_CNT_LO);
		d = rv;
		@(posedge ref_clk) pin <= 0;
		@(posedge ref_clk) pin <= 1;
		rd(OFS_CNT_LO);
		chk(rv, d);
		chk({5'h00, iv}, 8'h00);
		@(posedge ref_clk) stop <= 0;
		@(posedge ref_clk) #1;
		chk({5'h00, iv}, 8'h04);
		rd(OFS_CAP_LO);
		chk(rv, d);
		chk({7'h00, woke}, 8'h01);
		@(posedge ref_clk) stop <= 1;
		@(posedge ref_clk) pin <= 0;
		@(posedge ref_clk) pin <= 1;
		@(posedge ref_clk) rstn <= 0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1;
		@(posedge ref_clk) stop <= 0;
		rd(OFS_STAT);
		chk(rv & 8'h80, 8'h00);
		rd(OFS_CNT_HI);
		chk(rv, CNT_RESET[15:8]);
		chk({7'h00, cmp_pin}, 8'h00);
		conclude();
	end
endmodule // tcsu_timer_tb

// >>> hw/tcsu_pkg.sv
package tcsu_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;

	// Register offsets, one byte each
	localparam logic [7:0] OFS_CTRL = 8'h12;
	localparam logic [7:0] OFS_STAT = 8'h13;
	localparam logic [7:0] OFS_CAP_HI = 8'h14;
	localparam logic [7:0] OFS_CAP_LO = 8'h15;
	localparam logic [7:0] OFS_CMP_HI = 8'h16;
	localparam logic [7:0] OFS_CMP_LO = 8'h17;
	localparam logic [7:0] OFS_CNT_HI = 8'h18;
	localparam logic [7:0] OFS_CNT_LO = 8'h19;
	localparam logic [7:0] OFS_ALT_HI = 8'h1A;
	localparam logic [7:0] OFS_ALT_LO = 8'h1B;

	// timer_control_reg fields
	localparam int CTRL_CAP_IE = 7;
	localparam int CTRL_CMP_IE = 6;
	localparam int CTRL_ROLL_IE = 5;
	localparam int CTRL_EDGE = 1;
	localparam int CTRL_LVL = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hE3;

	// timer_status_reg fields
	localparam int STAT_CAP = 7;
	localparam int STAT_CMP = 6;
	localparam int STAT_ROLL = 5;

	// Flag vector index
	localparam int FLG_CAP = 0;
	localparam int FLG_CMP = 1;
	localparam int FLG_ROLL = 2;
	localparam int FLG_N = 3;

	localparam logic [15:0] CNT_RESET = 16'hFFFC;
	localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
	localparam int PRESCALE = 4;
	localparam int PRESC_W = 2;
	localparam logic [1:0] PRESC_LAST = 2'(PRESCALE - 1);
	localparam logic [1:0] PRESC_FIRST = 2'h0;

endpackage

// >>> hw/tcsu_timer.sv
module tcsu_timer (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [tcsu_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [tcsu_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [tcsu_pkg::DATA_W-1:0] reg_rdata,
	input wire logic capture_input_pin,
	input wire logic stop_mode,
	output logic compare_output_pin,
	output logic capture_irq,
	output logic compare_irq,
	output logic rollover_irq,
	output logic timer_irq
);
	import tcsu_pkg::*;

	logic [DATA_W-1:0] ctrl_q;
	logic [PRESC_W-1:0] presc_q;
	logic [CNT_W-1:0] count_q;
	logic [DATA_W-1:0] cmp_hi_q;
	logic [DATA_W-1:0] cmp_lo_q;
	logic cmp_inhibit_q;
	logic cmp_out_q;
	logic [DATA_W-1:0] cap_hi_q;
	logic [DATA_W-1:0] cap_lo_q;
	logic cap_inhibit_q;
	logic pin_q;
	logic pin_seen_q;
	logic stop_armed_q;
	logic cap_flag_q;
	logic cmp_flag_q;
	logic roll_flag_q;
	logic [FLG_N-1:0] arm_q;
	logic [DATA_W-1:0] rdata_q;

	// Address decode
	wire sel_ctrl = reg_addr == OFS_CTRL;
	wire sel_stat = reg_addr == OFS_STAT;
	wire sel_cap_hi = reg_addr == OFS_CAP_HI;
	wire sel_cap_lo = reg_addr == OFS_CAP_LO;
	wire sel_cmp_hi = reg_addr == OFS_CMP_HI;
	wire sel_cmp_lo = reg_addr == OFS_CMP_LO;
	wire sel_cnt_hi = reg_addr == OFS_CNT_HI;
	wire sel_cnt_lo = reg_addr == OFS_CNT_LO;
	wire sel_alt_hi = reg_addr == OFS_ALT_HI;
	wire sel_alt_lo = reg_addr == OFS_ALT_LO;

	wire wr_ctrl = reg_wr & sel_ctrl;
	wire wr_cmp_hi = reg_wr & sel_cmp_hi;
	wire wr_cmp_lo = reg_wr & sel_cmp_lo;
	wire rd_stat = reg_rd & sel_stat;
	wire rd_cap_hi = reg_rd & sel_cap_hi;
	wire rd_cap_lo = reg_rd & sel_cap_lo;
	wire rd_cnt_lo = reg_rd & sel_cnt_lo;

	// Timebase: count, prescaler and compare frozen while the phase clock is stopped; capture edges are still latched
	wire running = ~stop_mode;
	wire tick = running & (presc_q == PRESC_LAST);
	wire rollover = tick & (count_q == CNT_ALL_ONES);
	wire cmp_phase = running & (presc_q == PRESC_FIRST);
	wire match = cmp_phase & ~cmp_inhibit_q & ({cmp_hi_q, cmp_lo_q} == count_q);

	// Capture edge detector; pin_seen_q masks a false edge right after reset
	wire rise = capture_input_pin & ~pin_q & pin_seen_q;
	wire fall = ~capture_input_pin & pin_q & pin_seen_q;
	wire cap_edge = ctrl_q[CTRL_EDGE] ? rise : fall;
	wire cap_set = running & (cap_edge | stop_armed_q);
	wire cap_load = cap_set & ~cap_inhibit_q;

	wire [FLG_N-1:0] flags = {roll_flag_q, cmp_flag_q, cap_flag_q};
	wire [FLG_N-1:0] flag_set = {rollover, match, cap_set};
	wire [FLG_N-1:0] flag_access = {rd_cnt_lo, wr_cmp_lo, rd_cap_lo};
	wire [FLG_N-1:0] flag_clr = arm_q & flag_access;

	wire [DATA_W-1:0] stat_byte = {cap_flag_q, cmp_flag_q, roll_flag_q, 5'h00};

	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (sel_ctrl) begin
			rd_mux = ctrl_q & CTRL_WMASK;
		end
		if (sel_stat) begin
			rd_mux = stat_byte;
		end
		if (sel_cap_hi) begin
			rd_mux = cap_hi_q;
		end
		if (sel_cap_lo) begin
			rd_mux = cap_lo_q;
		end
		if (sel_cmp_hi) begin
			rd_mux = cmp_hi_q;
		end
		if (sel_cmp_lo) begin
			rd_mux = cmp_lo_q;
		end
		// Alternate pair shows the same count but has no clearing side effect
		if (sel_cnt_hi | sel_alt_hi) begin
			rd_mux = count_q[15:8];
		end
		if (sel_cnt_lo | sel_alt_lo) begin
			rd_mux = count_q[7:0];
		end
	end

	// Reset-affected state: control, counter, sequencing bits, capture flag, compare output and read data only
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RESET;
			presc_q <= '0;
			count_q <= CNT_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata & CTRL_WMASK;
			end
			if (running) begin
				presc_q <= presc_q + 2'h1;
			end
			if (tick) begin
				count_q <= count_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cmp_inhibit_q <= 1'b0;
			cmp_out_q <= 1'b0;
		end else begin
			// Writing the high byte holds off compares until the pair is whole
			if (wr_cmp_hi) begin
				cmp_inhibit_q <= 1'b1;
			end else if (wr_cmp_lo) begin
				cmp_inhibit_q <= 1'b0;
			end
			if (match) begin
				cmp_out_q <= ctrl_q[CTRL_LVL];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin_q <= 1'b0;
			pin_seen_q <= 1'b0;
			cap_inhibit_q <= 1'b0;
			stop_armed_q <= 1'b0;
			cap_flag_q <= 1'b0;
		end else begin
			pin_q <= capture_input_pin;
			pin_seen_q <= 1'b1;
			// High byte read freezes the pair until the low byte is read
			if (rd_cap_hi) begin
				cap_inhibit_q <= 1'b1;
			end else if (rd_cap_lo) begin
				cap_inhibit_q <= 1'b0;
			end
			if (running) begin
				stop_armed_q <= 1'b0;
			end else if (cap_edge) begin
				stop_armed_q <= 1'b1;
			end
			cap_flag_q <= flag_set[FLG_CAP] | (cap_flag_q & ~flag_clr[FLG_CAP]);
		end
	end

	// Data and flags that reset leaves alone; they hold whatever was there
	always_ff @(posedge ref_clk) begin
		if (wr_cmp_hi) begin
			cmp_hi_q <= reg_wdata;
		end
		if (wr_cmp_lo) begin
			cmp_lo_q <= reg_wdata;
		end
		if (cap_load) begin
			cap_hi_q <= count_q[15:8];
			cap_lo_q <= count_q[7:0];
		end
		cmp_flag_q <= flag_set[FLG_CMP] | (cmp_flag_q & ~flag_clr[FLG_CMP]);
		roll_flag_q <= flag_set[FLG_ROLL] | (roll_flag_q & ~flag_clr[FLG_ROLL]);
	end

	// Clear arming per flag; a status read re-samples which flags are armed
	genvar gi;
	generate
		for (gi = 0; gi < FLG_N; gi++) begin : g_arm
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					arm_q[gi] <= 1'b0;
				end else if (rd_stat) begin
					arm_q[gi] <= flags[gi] === 1'b1;
				end else if (flag_clr[gi]) begin
					arm_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : '0;
		end
	end

	assign reg_rdata = rdata_q;
	assign compare_output_pin = cmp_out_q;
	// Combinational so the request rises in the cycle its flag rises
	assign capture_irq = ctrl_q[CTRL_CAP_IE] & cap_flag_q;
	assign compare_irq = ctrl_q[CTRL_CMP_IE] & cmp_flag_q;
	assign rollover_irq = ctrl_q[CTRL_ROLL_IE] & roll_flag_q;
	assign timer_irq = capture_irq | compare_irq | rollover_irq;

endmodule // tcsu_timer
